// >>> verif/rstflt_sup.sv
// Board reset supervisor and strap pin model
`timescale 1ns/1ns
module rstflt_sup (
    input  wire logic                clk,
    output logic                     rin_n,
    output logic                     cfg_sel,
    output logic                     osc_sel,
    output rstflt_pkg::rstflt_boot_t boot
);
    import rstflt_pkg::*;
    // Idle: pin released high, straps low
    initial begin
        rin_n = 1'b1;
        cfg_sel = 1'b0;
        osc_sel = 1'b0;
        boot = 2'h0;
    end
    // Pin held low n clocks; call just after an edge
    task automatic hold_low(input int n);
        rin_n <= 1'b0;
        repeat (n) @(posedge clk);
        rin_n <= 1'b1;
    endtask
    // Straps must be settled well before reset ends
    task automatic straps(input logic s, input logic o,
                          input rstflt_boot_t b);
        cfg_sel <= s;
        osc_sel <= o;
        boot <= b;
    endtask
endmodule

// >>> verif/rstflt_top_bench.sv
// Self-checking bench for the reset filter and boot config block
`timescale 1ns/1ns
module rstflt_top_bench;
    import rstflt_pkg::*;
    localparam int HOLD = 8;
    typedef struct {
        logic         s;
        logic         o;
        rstflt_boot_t b;
        rstflt_osc_e  eo;
        rstflt_boot_t eb;
    } rstflt_row_s;
    rstflt_row_s  rows [4] = '{
        '{1'b0, 1'b0, 2'h1, RSTFLT_EXTREF, 2'h1},
        '{1'b0, 1'b1, 2'h2, RSTFLT_XTAL, 2'h2},
        '{1'b0, 1'b0, 2'h3, RSTFLT_EXTREF, 2'h3},
        '{1'b1, 1'b0, 2'h3, RSTFLT_XTAL, 2'h0}};
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    logic         ireq = 1'b0;
    logic         ce = 1'b1;
    logic         rin_n, cfg_sel, osc_sel, rso_n, oe, irst, glt;
    rstflt_boot_t boot, bopt, bopt2;
    rstflt_osc_e  osc, osc2;
    int           n_mismatch = 0;
    int           checked = 0;
    int           n;

    rstflt_sup i_rstflt_sup (.clk(clk), .rin_n(rin_n), .cfg_sel(cfg_sel),
        .osc_sel(osc_sel), .boot(boot));
    rstflt_top #(.HOLD_CYCLES(HOLD)) i_rstflt_top (
        .CORE_CLK(clk), .RST(rst), .CE(ce), .RESET_IN_N(rin_n),
        .INT_RESET_REQ(ireq), .CONFIG_SOURCE_SELECT(cfg_sel),
        .OSCILLATOR_MODE_SELECT(osc_sel), .BOOT_OPTION_PINS(boot),
        .RESET_STATUS_OUTPUT_N(rso_n), .RESET_STATUS_OE(oe),
        .INT_RESET(irst), .GLITCH_DET(glt), .OSC_MODE(osc),
        .BOOT_OPTION(bopt));
    // Package without select pin: same straps, select must be ignored
    rstflt_top #(.HOLD_CYCLES(HOLD), .HAS_CFG_SEL(1'b0)) i_rstflt_top_fix (
        .CORE_CLK(clk), .RST(rst), .CE(ce), .RESET_IN_N(rin_n),
        .INT_RESET_REQ(ireq), .CONFIG_SOURCE_SELECT(cfg_sel),
        .OSCILLATOR_MODE_SELECT(osc_sel), .BOOT_OPTION_PINS(boot),
        .RESET_STATUS_OUTPUT_N(), .RESET_STATUS_OE(), .INT_RESET(),
        .GLITCH_DET(), .OSC_MODE(osc2), .BOOT_OPTION(bopt2));

    // --------
    // Tasks
    // --------
    task automatic complete_run();
        if (n_mismatch == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %0h expected %0h",
                     $time, got, exp);
        end
    endtask
    task automatic cmp_val(input logic [1:0] got, input logic [1:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %0h expected %0h",
                     $time, got, exp);
        end
    endtask
    // Bounded wait for the internal reset level; k counts clocks
    task automatic wait_irst(input logic v, output int k);
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (irst !== v && k < 64);
        cmp_bit(irst, v);
    endtask
    // Status pin lags the internal reset by exactly two edges
    task automatic enter_reset();
        wait_irst(1'b1, n);
        cmp_bit(rso_n, 1'b1);
        repeat (2) @(posedge clk);
        #1;
        cmp_bit(rso_n, 1'b0);
        cmp_bit(oe, 1'b1);
    endtask
    // Short low run: must never reset, may flag a glitch
    task automatic short_low(input int len, input logic g_exp);
        logic g;
        logic r;
        g = 1'b0;
        r = 1'b0;
        @(posedge clk);
        i_rstflt_sup.hold_low(len);
        repeat (20) begin
            @(posedge clk);
            #1;
            g = g | glt;
            r = r | irst;
        end
        cmp_bit(g, g_exp);
        cmp_bit(r, 1'b0);
    endtask

    // --------
    // Main sequence
    // --------
    initial begin
        forever #4 clk = ~clk;
    end
    // Watchdog: whole run is well under a thousand clocks
    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        complete_run();
    end
    initial begin
        // Block reset holds the delay count, so the pin lags release
        repeat (15) @(posedge clk);
        #1;
        cmp_bit(irst, 1'b1);
        cmp_bit(rso_n, 1'b1);
        @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        cmp_bit(rso_n, 1'b0);
        wait_irst(1'b0, n);
        foreach (rows[i]) begin
            @(posedge clk);
            i_rstflt_sup.straps(rows[i].s, rows[i].o, rows[i].b);
            @(posedge clk);
            i_rstflt_sup.hold_low(10);
            enter_reset();
            wait_irst(1'b0, n);
            cmp_bit(rso_n, 1'b1);
            cmp_bit(osc, rows[i].eo);
            cmp_val(bopt, rows[i].eb);
            cmp_bit(osc2, rows[i].o);
            cmp_val(bopt2, rows[i].b);
            @(posedge clk);
            i_rstflt_sup.straps(~rows[i].s, ~rows[i].o, ~rows[i].b);
            repeat (6) @(posedge clk);
            #1;
            cmp_bit(osc, rows[i].eo);
            cmp_val(bopt, rows[i].eb);
        end
        short_low(9, 1'b1);
        short_low(3, 1'b1);
        short_low(2, 1'b0);
        // Internal source alone must also pull the status pin low
        @(posedge clk);
        ireq <= 1'b1;
        @(posedge clk);
        ireq <= 1'b0;
        enter_reset();
        // Enable low freezes the hold count, reset must stay on
        @(posedge clk);
        ce <= 1'b0;
        repeat (20) @(posedge clk);
        #1;
        cmp_bit(irst, 1'b1);
        cmp_bit(rso_n, 1'b0);
        @(posedge clk);
        ce <= 1'b1;
        wait_irst(1'b0, n);
        // Pin asserted again while the hold count is still running
        @(posedge clk);
        i_rstflt_sup.hold_low(10);
        wait_irst(1'b1, n);
        @(posedge clk);
        i_rstflt_sup.hold_low(10);
        wait_irst(1'b0, n);
        cmp_bit(n >= HOLD, 1'b1);
        // Mid-run block reset: pin lags release, straps taken afresh
        @(posedge clk);
        i_rstflt_sup.straps(1'b0, 1'b0, 2'h2);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        cmp_bit(irst, 1'b1);
        cmp_bit(rso_n, 1'b1);
        @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        cmp_bit(rso_n, 1'b0);
        wait_irst(1'b0, n);
        cmp_bit(osc, RSTFLT_EXTREF);
        cmp_val(bopt, 2'h2);
        complete_run();
    end
endmodule

// >>> verilog/rstflt_consts.svh
// Constants for the reset input filter and boot configuration block
`ifndef RSTFLT_CONSTS_SVH
`define RSTFLT_CONSTS_SVH

// Reset pulse width needed before internal reset starts, in clocks
`define RSTFLT_MIN_PULSE      10
// Glitch width recognised on the reset input, in clocks
`define RSTFLT_GLITCH_WIDTH   2
// Clocks from internal reset start to reset output asserting
`define RSTFLT_OUT_DELAY      2
// Clocks the internal reset is held after the input releases
`define RSTFLT_HOLD_CYCLES    16
// Boot option default: internal flash
`define RSTFLT_BOOT_DEFAULT   2'h0
// Oscillator mode encodings
`define RSTFLT_OSC_EXTREF     1'h0
`define RSTFLT_OSC_XTAL       1'h1

`endif

// >>> verilog/rstflt_pkg.sv
// Types for the reset input filter and boot configuration block
package rstflt_pkg;
    typedef enum logic { RSTFLT_EXTREF, RSTFLT_XTAL } rstflt_osc_e;
    typedef logic [1:0] rstflt_boot_t;
endpackage

// >>> verilog/rstflt_sync.sv
// Three-stage input synchroniser with agreement detection
`timescale 1ns/1ns
module rstflt_sync #(
    parameter int          WIDTH    = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] out_r;
    logic [WIDTH-1:0] out_nxt;

    // -----------------------------------------------------------------
    // Per-bit agreement: value changes once stages two and three agree
    // -----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_comb begin
                out_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : out_r[g];
            end
        end
    endgenerate

    // Stage one is read only by stage two
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_r  <= INIT;
            s2_r  <= INIT;
            s3_r  <= INIT;
            out_r <= INIT;
        end else if (ce) begin
            s1_r  <= din;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            out_r <= out_nxt;
        end
    end

    assign dout = out_r;
endmodule

// >>> verilog/rstflt_top.sv
// Reset input filter, reset status output and boot configuration capture
`timescale 1ns/1ns
`include "rstflt_consts.svh"

// Notes on behaviour
// (RL1) Internal reset starts only after input held low for ten clocks; INT_RESET_REQ alone also starts it, with no low input.
// (RL2) Input asserted again during reset restarts the reset cycle.
// (RL3) Glitch detector flags low spikes longer than two clocks.
// (RL4) Outside party drives reset input low for power-on or external reset.
// (RL5) Reset status output goes low for every reset, internal or external.
// (RL6) Reset status output is push-pull, driven both high and low.
// (RL7) Reset status output asserts a delay after the reset begins.
// (RL8) Source select 0: boot option and oscillator mode from the pins.
// (RL9) Source select 1: default boot from flash with crystal oscillator.
// (RL10) Pin mode: oscillator select 0 means external ref, 1 crystal.
// (RL11) Clock input use follows oscillator select pin value during reset.
// (RL12) Variants without source select pin tie it to zero.
// (RL13) Configuration captured once per reset, held until next reset.
module rstflt_top #(
    parameter int MIN_PULSE   = `RSTFLT_MIN_PULSE,
    parameter int GLITCH_W    = `RSTFLT_GLITCH_WIDTH,
    parameter int OUT_DELAY   = `RSTFLT_OUT_DELAY,
    parameter int HOLD_CYCLES = `RSTFLT_HOLD_CYCLES,
    parameter bit HAS_CFG_SEL = 1'b1
) (
    input  wire logic                  CORE_CLK,
    input  wire logic                  RST,
    input  wire logic                  CE,
    input  wire logic                  RESET_IN_N,
    input  wire logic                  INT_RESET_REQ,
    input  wire logic                  CONFIG_SOURCE_SELECT,
    input  wire logic                  OSCILLATOR_MODE_SELECT,
    input  wire rstflt_pkg::rstflt_boot_t BOOT_OPTION_PINS,
    output logic                       RESET_STATUS_OUTPUT_N,
    output logic                       RESET_STATUS_OE,
    output logic                       INT_RESET,
    output logic                       GLITCH_DET,
    output rstflt_pkg::rstflt_osc_e    OSC_MODE,
    output rstflt_pkg::rstflt_boot_t   BOOT_OPTION
);
    import rstflt_pkg::*;

    typedef enum logic [1:0] { RSTFLT_RUN, RSTFLT_ACTIVE } rstflt_st_e;

    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------
    logic [3:0] pin_raw;
    logic [3:0] pin_sync;

    assign pin_raw = {RESET_IN_N, CONFIG_SOURCE_SELECT,
                      OSCILLATOR_MODE_SELECT, BOOT_OPTION_PINS[0]};

    // Reset input idles high, so the synchroniser presets that bit
    rstflt_sync #(
        .WIDTH (4),
        .INIT  (4'h8)
    ) u_sync (
        .clk  (CORE_CLK),
        .rst  (RST),
        .ce   (CE),
        .din  (pin_raw),
        .dout (pin_sync)
    );

    logic       boot1_sync;
    rstflt_sync #(
        .WIDTH (1),
        .INIT  (1'h0)
    ) u_sync_b1 (
        .clk  (CORE_CLK),
        .rst  (RST),
        .ce   (CE),
        .din  (BOOT_OPTION_PINS[1]),
        .dout (boot1_sync)
    );

    logic rst_in_low;
    logic cfg_sel;
    assign rst_in_low = ~pin_sync[3];
    // Missing select pin reads as zero, pins always used [RL12]
    assign cfg_sel    = HAS_CFG_SEL ? pin_sync[2] : 1'b0;

    // ------------------------------------------------------------------
    // Configuration decode
    // ------------------------------------------------------------------
    // Pin mapping, or fixed default when select is one [RL8] [RL9]
    function automatic rstflt_osc_e osc_decode(input logic sel,
                                               input logic pin);
        if (sel)
            return RSTFLT_XTAL;
        return pin ? RSTFLT_XTAL : RSTFLT_EXTREF;  // [RL10]
    endfunction

    function automatic rstflt_boot_t boot_decode(input logic sel,
                                                 input rstflt_boot_t pins);
        return sel ? rstflt_boot_t'(`RSTFLT_BOOT_DEFAULT) : pins;
    endfunction

    // ------------------------------------------------------------------
    // Low-pulse width filter and glitch detector
    // ------------------------------------------------------------------
    logic [7:0] low_cnt_r;
    logic [7:0] low_cnt_nxt;
    logic       glitch_r;
    logic       glitch_nxt;
    logic       pulse_ok;

    // Saturating count of consecutive low samples
    assign pulse_ok = (low_cnt_r >= 8'(MIN_PULSE));  // [RL1]

    always_comb begin
        low_cnt_nxt = low_cnt_r;
        glitch_nxt  = 1'b0;
        if (rst_in_low) begin
            if (low_cnt_r != 8'hFF)
                low_cnt_nxt = low_cnt_r + 8'h01;
        end else begin
            low_cnt_nxt = 8'h00;
            // Short low spike above glitch width, too short to reset [RL3]
            if (low_cnt_r > 8'(GLITCH_W) && low_cnt_r < 8'(MIN_PULSE))
                glitch_nxt = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Reset sequencing
    // ------------------------------------------------------------------
    rstflt_st_e state_r;
    rstflt_st_e state_nxt;
    logic [7:0] hold_r;
    logic [7:0] hold_nxt;
    logic [7:0] dly_r;
    logic [7:0] dly_nxt;
    logic       start_rst;
    logic       cfg_take;

    // Either a qualified pin reset or an internal request
    assign start_rst = pulse_ok | INT_RESET_REQ;

    always_comb begin
        state_nxt = state_r;
        hold_nxt  = hold_r;
        dly_nxt   = dly_r;
        unique case (state_r)
            RSTFLT_RUN: begin
                if (start_rst) begin
                    state_nxt = RSTFLT_ACTIVE;  // [RL1]
                    hold_nxt  = 8'(HOLD_CYCLES);
                    dly_nxt   = 8'h00;
                end
            end
            RSTFLT_ACTIVE: begin
                if (dly_r != 8'(OUT_DELAY))
                    dly_nxt = dly_r + 8'h01;
                // Any reassertion reloads the hold count; the delay count runs on [RL2]
                if (start_rst || rst_in_low)
                    hold_nxt = 8'(HOLD_CYCLES);
                else if (hold_r != 8'h00)
                    hold_nxt = hold_r - 8'h01;
                else
                    state_nxt = RSTFLT_RUN;
            end
            default: state_nxt = RSTFLT_RUN;
        endcase
    end

    // Configuration is sampled on the last cycle of reset [RL11] [RL13]
    assign cfg_take = (state_r == RSTFLT_ACTIVE) && (state_nxt == RSTFLT_RUN);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    rstflt_osc_e  osc_r;
    rstflt_boot_t boot_r;

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            low_cnt_r <= 8'h00;
            glitch_r  <= 1'b0;
            state_r   <= RSTFLT_ACTIVE;
            hold_r    <= 8'(HOLD_CYCLES);
            dly_r     <= 8'h00;
            osc_r     <= RSTFLT_XTAL;
            boot_r    <= rstflt_boot_t'(`RSTFLT_BOOT_DEFAULT);
        end else if (CE) begin
            low_cnt_r <= low_cnt_nxt;
            glitch_r  <= glitch_nxt;
            state_r   <= state_nxt;
            hold_r    <= hold_nxt;
            dly_r     <= dly_nxt;
            if (cfg_take) begin
                osc_r  <= osc_decode(cfg_sel, pin_sync[1]);
                boot_r <= boot_decode(cfg_sel, {boot1_sync, pin_sync[0]});
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    logic out_low;
    // Status output lags reset start by the delay count [RL5] [RL7]
    assign out_low = (state_r == RSTFLT_ACTIVE) &&
                     (dly_r == 8'(OUT_DELAY));

    assign RESET_STATUS_OUTPUT_N = ~out_low;
    assign RESET_STATUS_OE       = 1'b1;  // Push-pull, always driven [RL6]
    assign INT_RESET             = (state_r == RSTFLT_ACTIVE);
    assign GLITCH_DET            = glitch_r;
    assign OSC_MODE              = osc_r;
    assign BOOT_OPTION           = boot_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    sequence s_run_start;
        CE && state_r == RSTFLT_RUN && start_rst;
    endsequence

    // Three enabled clocks bring the delay count to its end
    sequence s_delay_done;
        CE [*3];
    endsequence

    chk_no_short_start: assert property (  // [RL1]
        $rose(INT_RESET) |->
            ($past(start_rst) && $past(CE)) || $past(RST))
        else $error("internal reset start without cause");

    // Qualified pin pulse always starts a reset
    chk_start_from_pin: assert property (  // [RL1]
        (CE && state_r == RSTFLT_RUN && pulse_ok) |=> INT_RESET)
        else $error("qualified pulse did not start reset");

    chk_start_needs_pulse: assert property (  // [RL1]
        (CE && state_r == RSTFLT_RUN && !INT_RESET_REQ &&
         low_cnt_r < 8'(MIN_PULSE)) |=> !INT_RESET)
        else $error("reset started by short pulse");

    chk_restart_hold: assert property (  // [RL2]
        (CE && state_r == RSTFLT_ACTIVE && rst_in_low) |=>
            hold_r == 8'(HOLD_CYCLES))
        else $error("reset cycle not restarted");

    chk_glitch_flag: assert property (  // [RL3]
        (CE && !rst_in_low && low_cnt_r == 8'(GLITCH_W + 1) &&
         GLITCH_W + 1 < MIN_PULSE) |=> GLITCH_DET)
        else $error("glitch not detected");

    // Spikes up to the glitch width pass unflagged
    chk_no_glitch_short: assert property (  // [RL3]
        (CE && !rst_in_low && low_cnt_r <= 8'(GLITCH_W)) |=> !GLITCH_DET)
        else $error("glitch flagged for short spike");

    chk_out_delay: assert property (  // [RL7]
        s_run_start ##1 s_delay_done |-> !RESET_STATUS_OUTPUT_N ||
            state_r != RSTFLT_ACTIVE)
        else $error("reset output not asserted after delay");

    chk_out_not_same: assert property (  // [RL7]
        s_run_start |=> RESET_STATUS_OUTPUT_N)
        else $error("reset output asserted with no delay");

    chk_out_in_reset: assert property (  // [RL5]
        !RESET_STATUS_OUTPUT_N |-> INT_RESET)
        else $error("reset output low outside reset");

    chk_push_pull: assert property (RESET_STATUS_OE)  // [RL6]
        else $error("reset output not driven");

    chk_default_cfg: assert property (  // [RL9]
        (CE && cfg_take && cfg_sel) |=>
            OSC_MODE == RSTFLT_XTAL && BOOT_OPTION == 2'h0)
        else $error("default configuration not applied");

    chk_pin_osc: assert property (  // [RL10]
        (CE && cfg_take && !cfg_sel) |=>
            OSC_MODE == rstflt_osc_e'($past(pin_sync[1])))
        else $error("oscillator mode does not follow pin");

    // Boot option bits follow their own pins
    chk_pin_boot: assert property (  // [RL8]
        (CE && cfg_take && !cfg_sel) |=>
            BOOT_OPTION[1] == $past(boot1_sync) &&
            BOOT_OPTION[0] == $past(pin_sync[0]))
        else $error("boot option does not follow pins");

    // Enable low freezes the sequencer, so a stall stretches reset
    chk_ce_freeze: assert property (
        !CE |=> $stable(state_r) && $stable(hold_r) && $stable(dly_r))
        else $error("state moved with clock enable low");

    chk_cfg_held: assert property (  // [RL13]
        (state_r == RSTFLT_RUN && $past(state_r) == RSTFLT_RUN) |->
            $stable(OSC_MODE) && $stable(BOOT_OPTION))
        else $error("configuration changed outside reset");
endmodule
